// >>> lsr_pkg.sv
// Package with register map, field layout and types of the light sensor readout
package lsr_pkg;
    localparam logic [7:0] ADDR_DARK_TRIP = 8'h39;
    localparam logic [7:0] ADDR_DARK_HYST = 8'h3A;
    localparam logic [7:0] ADDR_S1_HIGH = 8'h3B;
    localparam logic [7:0] ADDR_S1_LOW = 8'h3C;
    localparam logic [7:0] ADDR_S2_HIGH = 8'h3D;
    localparam logic [7:0] ADDR_S2_LOW = 8'h3E;
    localparam logic [7:0] DARK_HYST_RESET = 8'h00;
    localparam logic [7:0] DARK_TRIP_RESET = 8'h00;
    localparam logic [12:0] RESULT_RESET = 13'h0000;
    localparam logic [7:0] RDATA_RESET = 8'h00;
    localparam int RESULT_W = 13;
    localparam int HIGH_LSB = 8;
    // Dark registers step 0.5 uA, result codes step 0.125 uA: shift by 2
    localparam int DARK_TO_CODE_SHIFT = 2;
    localparam logic [12:0] FULL_SCALE_CODE = 13'h1F40;

    typedef logic [12:0] lsr_result_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } lsr_bus_s;

    typedef enum logic [1:0] {
        LSR_OFFICE = 2'b01,
        LSR_DARK = 2'b10
    } lsr_mode_e;
endpackage : lsr_pkg

// >>> lsr_readout.sv
// Dark-level comparator and result registers of two light sensors
`timescale 1ns/1ps
module lsr_readout (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire lsr_pkg::lsr_bus_s bus_i,
    output logic [7:0] rdata_o,
    input wire logic s1_valid_i,
    input wire lsr_pkg::lsr_result_t s1_result_i,
    input wire logic s2_valid_i,
    input wire lsr_pkg::lsr_result_t s2_result_i,
    output logic dark_level_flag_o,
    output logic mode_change_o
);
    // ****************************************
    // Registers
    // ****************************************
    logic [7:0] dark_trip_level_q;
    logic [7:0] dark_hyst_value_q;
    lsr_pkg::lsr_result_t s1_q;
    lsr_pkg::lsr_result_t s2_q;
    lsr_pkg::lsr_mode_e mode_q;
    lsr_pkg::lsr_mode_e mode_d;
    logic change_q;
    logic [7:0] rdata_q;

    wire wr_trip = bus_i.wr && bus_i.addr == lsr_pkg::ADDR_DARK_TRIP;
    wire wr_hyst = bus_i.wr && bus_i.addr == lsr_pkg::ADDR_DARK_HYST;

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            dark_trip_level_q <= lsr_pkg::DARK_TRIP_RESET;
            dark_hyst_value_q <= lsr_pkg::DARK_HYST_RESET;
        end else begin
            if (wr_trip) begin
                dark_trip_level_q <= bus_i.wdata;
            end
            if (wr_hyst) begin
                dark_hyst_value_q <= bus_i.wdata;
            end
        end
    end

    // Latest conversion only; bus writes never touch these
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            s1_q <= lsr_pkg::RESULT_RESET;
            s2_q <= lsr_pkg::RESULT_RESET;
        end else begin
            if (s1_valid_i) begin
                s1_q <= s1_result_i;
            end
            if (s2_valid_i) begin
                s2_q <= s2_result_i;
            end
        end
    end

    // ****************************************
    // Dark comparator
    // ****************************************
    // Thresholds scaled into result codes of 0.125 uA each
    wire [12:0] trip_code = {3'h0, dark_trip_level_q, 2'h0};
    wire [12:0] exit_code = 13'(({2'h0, dark_trip_level_q}
        + {2'h0, dark_hyst_value_q}) << lsr_pkg::DARK_TO_CODE_SHIFT);
    wire go_dark = s2_q < trip_code;
    wire go_office = s2_q > exit_code;

    always_comb begin
        mode_d = mode_q;
        unique case (mode_q)
            lsr_pkg::LSR_OFFICE: begin
                if (go_dark) begin
                    mode_d = lsr_pkg::LSR_DARK;
                end
            end
            lsr_pkg::LSR_DARK: begin
                if (go_office) begin
                    mode_d = lsr_pkg::LSR_OFFICE;
                end
            end
            default: mode_d = lsr_pkg::LSR_OFFICE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            mode_q <= lsr_pkg::LSR_OFFICE;
            change_q <= 1'b0;
        end else begin
            mode_q <= mode_d;
            change_q <= mode_d != mode_q;
        end
    end

    assign dark_level_flag_o = mode_q == lsr_pkg::LSR_DARK;
    assign mode_change_o = change_q;

    // ****************************************
    // Read path
    // ****************************************
    wire [7:0] s1_high = {3'h0, s1_q[12:lsr_pkg::HIGH_LSB]};
    wire [7:0] s1_low = s1_q[7:0];
    wire [7:0] s2_high = {3'h0, s2_q[12:lsr_pkg::HIGH_LSB]};
    wire [7:0] s2_low = s2_q[7:0];
    wire [7:0] rd_mux =
        bus_i.addr == lsr_pkg::ADDR_DARK_TRIP ? dark_trip_level_q :
        bus_i.addr == lsr_pkg::ADDR_DARK_HYST ? dark_hyst_value_q :
        bus_i.addr == lsr_pkg::ADDR_S1_HIGH ? s1_high :
        bus_i.addr == lsr_pkg::ADDR_S1_LOW ? s1_low :
        bus_i.addr == lsr_pkg::ADDR_S2_HIGH ? s2_high :
        bus_i.addr == lsr_pkg::ADDR_S2_LOW ? s2_low : 8'h00;

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            rdata_q <= lsr_pkg::RDATA_RESET;
        end else if (bus_i.rd) begin
            rdata_q <= rd_mux;
        end
    end
    assign rdata_o = rdata_q;

    // ****************************************
    // Checks
    // ****************************************
    a_enter_dark: assert property (
        @(posedge clk_i) disable iff (reset_i)
        mode_q == lsr_pkg::LSR_OFFICE && go_dark |=> dark_level_flag_o)
        else $error("dark mode not entered");
    a_leave_dark: assert property (
        @(posedge clk_i) disable iff (reset_i)
        mode_q == lsr_pkg::LSR_DARK && go_office |=> !dark_level_flag_o)
        else $error("dark mode not left");
    a_hold_dark: assert property (
        @(posedge clk_i) disable iff (reset_i)
        mode_q == lsr_pkg::LSR_DARK && !go_office |=> dark_level_flag_o)
        else $error("dark mode left early");
    a_hyst_store: assert property (
        @(posedge clk_i) disable iff (reset_i)
        wr_hyst |=> dark_hyst_value_q == $past(bus_i.wdata))
        else $error("hysteresis not stored");
    a_s1_high_read: assert property (
        @(posedge clk_i) disable iff (reset_i)
        bus_i.rd && bus_i.addr == lsr_pkg::ADDR_S1_HIGH
        |=> rdata_o == {3'h0, $past(s1_q[12:8])})
        else $error("sensor 1 high wrong");
    a_s1_low_read: assert property (
        @(posedge clk_i) disable iff (reset_i)
        bus_i.rd && bus_i.addr == lsr_pkg::ADDR_S1_LOW
        |=> rdata_o == $past(s1_q[7:0]))
        else $error("sensor 1 low wrong");
    a_s1_latest: assert property (
        @(posedge clk_i) disable iff (reset_i)
        s1_valid_i |=> s1_q == $past(s1_result_i))
        else $error("sensor 1 not updated");
    a_s2_read: assert property (
        @(posedge clk_i) disable iff (reset_i)
        bus_i.rd && bus_i.addr == lsr_pkg::ADDR_S2_HIGH
        |=> rdata_o == {3'h0, $past(s2_q[12:8])})
        else $error("sensor 2 high wrong");
    a_change_pulse: assert property (
        @(posedge clk_i) disable iff (reset_i)
        $changed(dark_level_flag_o) |-> mode_change_o)
        else $error("mode change not signalled");
    a_result_ro: assert property (
        @(posedge clk_i) disable iff (reset_i)
        bus_i.wr && !s2_valid_i |=> $stable(s2_q))
        else $error("result written by bus");
    a_code_scale: assert property (
        @(posedge clk_i) disable iff (reset_i)
        trip_code == 13'(dark_trip_level_q) * 13'h4)
        else $error("trip scaling wrong");
    a_reset_quiet: assert property (
        @(posedge clk_i)
        reset_i |=> !dark_level_flag_o && !mode_change_o)
        else $error("mode outputs not cleared by reset");
    a_reset_rdata: assert property (
        @(posedge clk_i)
        reset_i |=> rdata_o == lsr_pkg::RDATA_RESET)
        else $error("read data not cleared by reset");
    a_s2_low_read: assert property (
        @(posedge clk_i) disable iff (reset_i)
        bus_i.rd && bus_i.addr == lsr_pkg::ADDR_S2_LOW
        |=> rdata_o == $past(s2_q[7:0]))
        else $error("sensor 2 low wrong");
    a_hyst_read: assert property (
        @(posedge clk_i) disable iff (reset_i)
        bus_i.rd && bus_i.addr == lsr_pkg::ADDR_DARK_HYST
        |=> rdata_o == $past(dark_hyst_value_q))
        else $error("hysteresis read wrong");
    a_unmapped_zero: assert property (
        @(posedge clk_i) disable iff (reset_i)
        bus_i.rd && (bus_i.addr < lsr_pkg::ADDR_DARK_TRIP
        || bus_i.addr > lsr_pkg::ADDR_S2_LOW) |=> rdata_o == 8'h00)
        else $error("unmapped read not zero");
    a_high_pad: assert property (
        @(posedge clk_i) disable iff (reset_i)
        bus_i.rd && (bus_i.addr == lsr_pkg::ADDR_S1_HIGH
        || bus_i.addr == lsr_pkg::ADDR_S2_HIGH) |=> rdata_o[7:5] == 3'h0)
        else $error("unused result bits not zero");
    a_s2_latest: assert property (
        @(posedge clk_i) disable iff (reset_i)
        s2_valid_i |=> s2_q == $past(s2_result_i))
        else $error("sensor 2 not updated");
    a_s1_ro: assert property (
        @(posedge clk_i) disable iff (reset_i)
        bus_i.wr && !s1_valid_i |=> $stable(s1_q))
        else $error("sensor 1 result written by bus");
    a_rdata_hold: assert property (
        @(posedge clk_i) disable iff (reset_i)
        !bus_i.rd |=> $stable(rdata_o))
        else $error("read data changed without read");
    a_change_cause: assert property (
        @(posedge clk_i) disable iff (reset_i)
        mode_change_o |-> $changed(dark_level_flag_o))
        else $error("mode change without new mode");
    a_trip_store: assert property (
        @(posedge clk_i) disable iff (reset_i)
        wr_trip |=> dark_trip_level_q == $past(bus_i.wdata))
        else $error("trip level not stored");
    a_trip_range: assert property (
        @(posedge clk_i) disable iff (reset_i)
        exit_code < lsr_pkg::FULL_SCALE_CODE)
        else $error("threshold beyond full scale");
    a_hyst_order: assert property (
        @(posedge clk_i) disable iff (reset_i)
        exit_code >= trip_code)
        else $error("exit level below trip level");
    a_mode_legal: assert property (
        @(posedge clk_i) disable iff (reset_i)
        mode_q == lsr_pkg::LSR_OFFICE || mode_q == lsr_pkg::LSR_DARK)
        else $error("illegal mode code");
    a_hold_office: assert property (
        @(posedge clk_i) disable iff (reset_i)
        mode_q == lsr_pkg::LSR_OFFICE && !go_dark |=> !dark_level_flag_o)
        else $error("dark mode entered early");
    a_hyst_ignore: assert property (
        @(posedge clk_i) disable iff (reset_i)
        bus_i.wr && bus_i.addr != lsr_pkg::ADDR_DARK_HYST
        |=> $stable(dark_hyst_value_q))
        else $error("hysteresis changed by other write");
endmodule : lsr_readout

// >>> lsr_host.sv
// Host model issuing register cycles to the light sensor readout
`timescale 1ns/1ps
module lsr_host (
    input wire logic clk_i,
    output lsr_pkg::lsr_bus_s bus_o
);
    initial bus_o = '0;
    // One-cycle write or read pulse, launched on the falling edge
    task automatic acc(input logic w, input logic [7:0] a,
                       input logic [7:0] d);
        @(negedge clk_i);
        bus_o = '{wr: w, rd: !w, addr: a, wdata: d};
        @(negedge clk_i);
        bus_o = '0;
    endtask : acc
endmodule : lsr_host

// >>> lsr_readout_tb.sv
// Self-checking testbench of the light sensor readout
`timescale 1ns/1ps
module lsr_readout_tb;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    lsr_pkg::lsr_bus_s bus_i;
    logic [7:0] rdata_o;
    logic s1_valid_i = 1'b0;
    logic s2_valid_i = 1'b0;
    lsr_pkg::lsr_result_t s1_result_i = '0;
    lsr_pkg::lsr_result_t s2_result_i = '0;
    logic dark_level_flag_o, mode_change_o;
    logic rd_prev = 1'b0;
    logic [7:0] exp_q[$];
    int fail_count = 0;
    int checks_done = 0;
    int changes = 0;
    integer seed = 32'h7ED1DD8F;
    logic [12:0] r;
    logic [7:0] h;
    // ****
    // Clock, host model and design
    // ****
    initial forever #20 clk_i = ~clk_i;
    lsr_host lsr_host_i (.clk_i(clk_i), .bus_o(bus_i));
    lsr_readout lsr_readout_i (.clk_i(clk_i), .reset_i(reset_i),
        .bus_i(bus_i), .rdata_o(rdata_o), .s1_valid_i(s1_valid_i),
        .s1_result_i(s1_result_i), .s2_valid_i(s2_valid_i),
        .s2_result_i(s2_result_i), .dark_level_flag_o(dark_level_flag_o),
        .mode_change_o(mode_change_o));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        lsr_host_i.acc(1'b0, a, 8'h00);
    endtask : rd
    task automatic conv(input logic s, input logic [12:0] v);
        @(negedge clk_i);
        if (s) begin
            s2_result_i = v;
            s2_valid_i = 1'b1;
        end else begin
            s1_result_i = v;
            s1_valid_i = 1'b1;
        end
        @(negedge clk_i);
        s1_valid_i = 1'b0;
        s2_valid_i = 1'b0;
        repeat (3) @(negedge clk_i);
    endtask : conv
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : end_sim
    // Read data is compared with the oldest note
    always @(posedge clk_i) begin
        rd_prev <= bus_i.rd;
        if (mode_change_o === 1'b1) changes++;
    end
    always @(negedge clk_i) if (rd_prev) chk(rdata_o, exp_q.pop_front());
    initial begin
        #100000;
        fail_count++;
        end_sim();
    end
    initial begin
        repeat (10) @(negedge clk_i);
        reset_i = 1'b0;
        rd(8'h3A, 8'h00);
        rd(8'h3D, 8'h00);
        rd(8'h40, 8'h00);
        h = 8'($random(seed));
        lsr_host_i.acc(1'b1, 8'h3A, h);
        rd(8'h3A, h);
        $display("test registers done");
        for (int i = 0; i < 4; i++) begin
            r = 13'($unsigned($random(seed)) % lsr_pkg::FULL_SCALE_CODE);
            conv(i[0], r);
            rd(i[0] ? 8'h3D : 8'h3B, {3'h0, r[12:8]});
            rd(i[0] ? 8'h3E : 8'h3C, r[7:0]);
            lsr_host_i.acc(1'b1, i[0] ? 8'h3D : 8'h3B, 8'hFF);
            rd(i[0] ? 8'h3D : 8'h3B, {3'h0, r[12:8]});
        end
        $display("test results done");
        conv(1'b1, 13'h0C8);
        lsr_host_i.acc(1'b1, 8'h39, 8'h10);
        rd(8'h39, 8'h10);
        lsr_host_i.acc(1'b1, 8'h3A, 8'h08);
        changes = 0;
        conv(1'b1, 13'h03F);
        chk({7'h00, dark_level_flag_o}, 8'h01);
        conv(1'b1, 13'h060);
        chk({7'h00, dark_level_flag_o}, 8'h01);
        conv(1'b1, 13'h061);
        chk({7'h00, dark_level_flag_o}, 8'h00);
        chk(changes[7:0], 8'h02);
        $display("test comparator done");
        end_sim();
    end
endmodule : lsr_readout_tb
